// File: kpi_map.vh
// register map, field positions and reset values of the keypad pin interrupt block
`ifndef KPI_MAP_VH
`define KPI_MAP_VH

// register offsets (byte addresses on the plain register port)
`define KPI_ADDR_W          4
`define KPI_OFS_STATUS_CTRL 4'h0
`define KPI_OFS_PIN_ENABLE  4'h1
`define KPI_OFS_POLARITY    4'h2
`define KPI_OFS_PULL_ENABLE 4'h3
`define KPI_OFS_EVT_STATUS  4'h4
`define KPI_OFS_EVT_CLEAR   4'h5
`define KPI_OFS_EVT_ENABLE  4'h6

// status_control_register fields
`define KPI_SC_MODE_BIT     0
`define KPI_SC_IRQ_EN_BIT   1
`define KPI_SC_ACK_BIT      2
`define KPI_SC_FLAG_BIT     3

// event status / clear / enable layout
`define KPI_EVT_W           3
`define KPI_EVT_EDGE_BIT    0
`define KPI_EVT_LEVEL_BIT   1
`define KPI_EVT_HELD_BIT    2

// widths and reset values
`define KPI_PINS            8
`define KPI_DATA_W          8
`define KPI_RST_SC          4'h0
`define KPI_RST_PIN_ENABLE  8'h00
`define KPI_RST_POLARITY    8'h00
`define KPI_RST_PULL_ENABLE 8'h00
`define KPI_RST_EVT         3'h0

`endif

// File: kpi_pin_detect.v
// per-pin sampling, polarity folding and synchronous edge detection
`timescale 1ns/1ps
`include "kpi_map.vh"

module kpi_pin_detect (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire [`KPI_PINS-1:0]   pin_in,
  input  wire [`KPI_PINS-1:0]   pin_enable,
  input  wire [`KPI_PINS-1:0]   polarity,
  output wire [`KPI_PINS-1:0]   pin_asserted,
  output wire [`KPI_PINS-1:0]   pin_edge
);

  reg [`KPI_PINS-1:0] sample_now;
  reg [`KPI_PINS-1:0] sample_last;

  genvar i;
  generate
    for (i = 0; i < `KPI_PINS; i = i + 1) begin : g_pin
      wire now_act;
      wire last_act;

      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          sample_now[i]  <= 1'b0;
          sample_last[i] <= 1'b0;
        end else begin
          sample_now[i]  <= pin_in[i];
          sample_last[i] <= sample_now[i];
        end
      end

      // polarity 0 asserts low, polarity 1 asserts high
      assign now_act         = ~(sample_now[i] ^ polarity[i]);
      assign last_act        = ~(sample_last[i] ^ polarity[i]);
      assign pin_asserted[i] = pin_enable[i] & now_act;
      // deasserted in one bus cycle, asserted in the next
      assign pin_edge[i]     = pin_enable[i] & ~last_act & now_act;
    end
  endgenerate

endmodule

// File: kpi_evt_status.v
// sticky event status with write-one clear, enable mask and merged request
`timescale 1ns/1ps
`include "kpi_map.vh"

module kpi_evt_status (
  input  wire                   core_clk,
  input  wire                   rst_n,
  input  wire [`KPI_EVT_W-1:0]  evt_set,
  input  wire                   clr_wr,
  input  wire                   ena_wr,
  input  wire [`KPI_EVT_W-1:0]  wdata,
  output reg  [`KPI_EVT_W-1:0]  evt_status,
  output reg  [`KPI_EVT_W-1:0]  evt_enable,
  output wire                   evt_pending
);

  genvar i;
  generate
    for (i = 0; i < `KPI_EVT_W; i = i + 1) begin : g_evt
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          evt_status[i] <= 1'b0;
        end else if (evt_set[i]) begin
          // a new event beats a clear in the same cycle
          evt_status[i] <= 1'b1;
        end else if (clr_wr && wdata[i]) begin
          evt_status[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_enable <= `KPI_RST_EVT;
    end else if (ena_wr) begin
      evt_enable <= wdata;
    end
  end

  assign evt_pending = |(evt_status & evt_enable);

endmodule

// File: kpi_top.v
// keypad pin interrupt block: registers, arming, event flag and request
//
// Contract
// - per-pin polarity bit: 0 falling edge or low, 1 rising edge or high.
// - up to eight inputs, each with its own enable; disabled pins are ignored.
// - one mode bit makes all enabled pins edge-only or edge-and-level.
// - enabled pin sampled high then low next cycle is a falling edge.
// - enabled pin sampled low then high next cycle is a rising edge.
// - edges are armed only while every enabled pin is deasserted.
// - in edge-only mode a valid edge sets the sticky event flag.
// - flag set and interrupt enable set give an interrupt request.
// - writing one to the acknowledge bit clears the event flag.
// - in edge-and-level mode an edge or asserted level sets the flag.
// - in edge-and-level mode acknowledge clears only when all pins deasserted.
// - with pull enabled, polarity 0 selects pull-up, 1 selects pull-down.
// - flag reads one after an event; writes to the flag bit do nothing.
// - acknowledge reads zero; status bits seven to four read zero.
// - mode bit 0 gives edge-only, 1 gives edges and levels.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "kpi_map.vh"

module kpi_top (
  input  wire                    core_clk,
  input  wire                    rst_n,
  input  wire [`KPI_ADDR_W-1:0]  reg_addr,
  input  wire [`KPI_DATA_W-1:0]  reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`KPI_DATA_W-1:0]  reg_rdata,
  input  wire [`KPI_PINS-1:0]    kbd_pin,
  output reg                     irq,
  output reg  [`KPI_PINS-1:0]    pull_up_en,
  output reg  [`KPI_PINS-1:0]    pull_down_en
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  reg                          detect_mode_bit;
  reg                          irq_enable_bit;
  reg                          event_flag;
  reg  [`KPI_PINS-1:0]         pin_enable_register;
  reg  [`KPI_PINS-1:0]         edge_polarity_select;
  reg  [`KPI_PINS-1:0]         port_pull_enable;
  reg                          edge_armed;

  wire [`KPI_PINS-1:0]         pin_asserted;
  wire [`KPI_PINS-1:0]         pin_edge;
  wire [`KPI_EVT_W-1:0]        evt_status;
  wire [`KPI_EVT_W-1:0]        evt_enable;
  wire                         evt_pending;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  wire sel_sc;
  wire sel_pe;
  wire sel_pol;
  wire sel_pull;
  wire sel_evt_sts;
  wire sel_evt_clr;
  wire sel_evt_ena;

  assign sel_sc      = (reg_addr == `KPI_OFS_STATUS_CTRL);
  assign sel_pe      = (reg_addr == `KPI_OFS_PIN_ENABLE);
  assign sel_pol     = (reg_addr == `KPI_OFS_POLARITY);
  assign sel_pull    = (reg_addr == `KPI_OFS_PULL_ENABLE);
  assign sel_evt_sts = (reg_addr == `KPI_OFS_EVT_STATUS);
  assign sel_evt_clr = (reg_addr == `KPI_OFS_EVT_CLEAR);
  assign sel_evt_ena = (reg_addr == `KPI_OFS_EVT_ENABLE);

  wire wr_sc;
  wire wr_pe;
  wire wr_pol;
  wire wr_pull;
  wire ack_wr;

  assign wr_sc   = reg_wr & sel_sc;
  assign wr_pe   = reg_wr & sel_pe;
  assign wr_pol  = reg_wr & sel_pol;
  assign wr_pull = reg_wr & sel_pull;
  assign ack_wr  = wr_sc & reg_wdata[`KPI_SC_ACK_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and edge finding

  kpi_pin_detect u_detect (
    .core_clk     (core_clk),
    .rst_n        (rst_n),
    .pin_in       (kbd_pin),
    .pin_enable   (pin_enable_register),
    .polarity     (edge_polarity_select),
    .pin_asserted (pin_asserted),
    .pin_edge     (pin_edge)
  );

  wire any_asserted;
  wire any_edge;
  wire edge_valid;
  wire level_valid;

  assign any_asserted = |pin_asserted;
  assign any_edge     = |pin_edge;

  // an edge only counts while armed
  assign edge_valid   = edge_armed & any_edge;
  // levels only count in edge-and-level mode
  assign level_valid  = detect_mode_bit & any_asserted;

  ////////////////////////////////////////////////////////////////////////////
  // arming: disarmed by any edge, rearmed once all enabled pins are idle

  reg next_edge_armed;

  always @* begin
    next_edge_armed = edge_armed;
    if (any_edge) begin
      next_edge_armed = 1'b0;
    end else if (!any_asserted) begin
      next_edge_armed = 1'b1;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_armed <= 1'b0;
    end else begin
      edge_armed <= next_edge_armed;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event flag

  wire flag_set;
  wire ack_allowed;
  wire ack_refused;

  assign flag_set    = edge_valid | level_valid;
  // in level mode an asserted pin holds the flag against acknowledge
  assign ack_allowed = ~detect_mode_bit | ~any_asserted;
  assign ack_refused = ack_wr & ~ack_allowed;

  reg next_event_flag;

  always @* begin
    next_event_flag = event_flag;
    if (flag_set) begin
      next_event_flag = 1'b1;
    end else if (ack_wr && ack_allowed) begin
      next_event_flag = 1'b0;
    end
  end

  // the flag bit of a write is ignored; only acknowledge clears it
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      event_flag <= 1'b0;
    end else begin
      event_flag <= next_event_flag;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control registers

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      detect_mode_bit <= 1'b0;
      irq_enable_bit  <= 1'b0;
    end else if (wr_sc) begin
      detect_mode_bit <= reg_wdata[`KPI_SC_MODE_BIT];
      irq_enable_bit  <= reg_wdata[`KPI_SC_IRQ_EN_BIT];
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_enable_register <= `KPI_RST_PIN_ENABLE;
    end else if (wr_pe) begin
      pin_enable_register <= reg_wdata;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_polarity_select <= `KPI_RST_POLARITY;
    end else if (wr_pol) begin
      edge_polarity_select <= reg_wdata;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_pull_enable <= `KPI_RST_PULL_ENABLE;
    end else if (wr_pull) begin
      port_pull_enable <= reg_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pull resistor steering

  reg [`KPI_PINS-1:0] next_pull_up_en;
  reg [`KPI_PINS-1:0] next_pull_down_en;

  always @* begin
    next_pull_up_en   = port_pull_enable & ~edge_polarity_select;
    next_pull_down_en = port_pull_enable & edge_polarity_select;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pull_up_en   <= `KPI_RST_PULL_ENABLE;
      pull_down_en <= `KPI_RST_PULL_ENABLE;
    end else begin
      pull_up_en   <= next_pull_up_en;
      pull_down_en <= next_pull_down_en;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event status, clear and enable registers

  wire [`KPI_EVT_W-1:0] evt_set;

  assign evt_set[`KPI_EVT_EDGE_BIT]  = edge_valid;
  assign evt_set[`KPI_EVT_LEVEL_BIT] = level_valid;
  assign evt_set[`KPI_EVT_HELD_BIT]  = ack_refused;

  kpi_evt_status u_evt (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .evt_set     (evt_set),
    .clr_wr      (reg_wr & sel_evt_clr),
    .ena_wr      (reg_wr & sel_evt_ena),
    .wdata       (reg_wdata[`KPI_EVT_W-1:0]),
    .evt_status  (evt_status),
    .evt_enable  (evt_enable),
    .evt_pending (evt_pending)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interrupt request

  reg next_irq;

  always @* begin
    next_irq = (event_flag & irq_enable_bit) | evt_pending;
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= next_irq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path: data stand only in the cycle after the read strobe

  wire [`KPI_DATA_W-1:0] sc_value;

  // acknowledge and upper bits read as zero
  assign sc_value = {4'h0, event_flag, 1'b0, irq_enable_bit, detect_mode_bit};

  reg [`KPI_DATA_W-1:0] next_reg_rdata;

  always @* begin
    next_reg_rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `KPI_OFS_STATUS_CTRL: begin
          next_reg_rdata = sc_value;
        end
        `KPI_OFS_PIN_ENABLE: begin
          next_reg_rdata = pin_enable_register;
        end
        `KPI_OFS_POLARITY: begin
          next_reg_rdata = edge_polarity_select;
        end
        `KPI_OFS_PULL_ENABLE: begin
          next_reg_rdata = port_pull_enable;
        end
        `KPI_OFS_EVT_STATUS: begin
          next_reg_rdata = {5'h00, evt_status};
        end
        `KPI_OFS_EVT_ENABLE: begin
          next_reg_rdata = {5'h00, evt_enable};
        end
        default: begin
          next_reg_rdata = 8'h00;
        end
      endcase
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

endmodule

// File: kpi_top_sva.sv
// checker: port-level assertions of the keypad pin interrupt block
`timescale 1ns/1ps
`include "kpi_map.vh"
module kpi_top_sva (
  input wire logic                    core_clk,
  input wire logic                    rst_n,
  input wire logic [`KPI_ADDR_W-1:0]  reg_addr,
  input wire logic [`KPI_DATA_W-1:0]  reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [`KPI_DATA_W-1:0]  reg_rdata,
  input wire logic [`KPI_PINS-1:0]    kbd_pin,
  input wire logic                    irq,
  input wire logic [`KPI_PINS-1:0]    pull_up_en,
  input wire logic [`KPI_PINS-1:0]    pull_down_en
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  reg [7:0] pe_shadow;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) pe_shadow <= 8'h00;
    else if (reg_wr && reg_addr == `KPI_OFS_PIN_ENABLE) pe_shadow <= reg_wdata;
  end
  sequence s_sc_read; reg_rd && reg_addr == 4'h0; endsequence
  sequence s_pe_read; reg_rd && reg_addr == 4'h1; endsequence
  property p_sc_read; s_sc_read |=> reg_rdata[7:4] == 4'h0 && !reg_rdata[2]; endproperty
  a_sc_read: assert property (p_sc_read) else $error("status read shows set spare bits");
  property p_pe_read; s_pe_read |=> reg_rdata == $past(pe_shadow); endproperty
  a_pe_read: assert property (p_pe_read) else $error("pin enable readback wrong");
  property p_rdata_idle; !reg_rd |=> reg_rdata == 8'h00; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read");
  property p_unmapped; reg_rd && (reg_addr > 4'h6 || reg_addr == 4'h5) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_pull_excl; (pull_up_en & pull_down_en) == 8'h00; endproperty
  a_pull_excl: assert property (p_pull_excl) else $error("pull up and down together");
  property p_pull_cause;
    $changed(pull_up_en) || $changed(pull_down_en) |-> $past(reg_wr) || $past(reg_wr, 2);
  endproperty
  a_pull_cause: assert property (p_pull_cause) else $error("pull changed without write");
  property p_reset_quiet;
    $rose(rst_n) |-> !irq && pull_up_en == 8'h00 && pull_down_en == 8'h00;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  property p_irq_cause;
    $rose(irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3)
      || $past(kbd_pin, 2) != $past(kbd_pin, 3) || $past(kbd_pin, 3) != $past(kbd_pin, 4);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("request without cause");
  property p_irq_fall; $fell(irq) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped without write");
endmodule
bind kpi_top kpi_top_sva chk_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .kbd_pin(kbd_pin), .irq(irq), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));

// File: kpi_keys.sv
// partner model: switches on the keypad pins with pulls and floating lines
`timescale 1ns/1ps
module kpi_keys (
  input  wire logic       core_clk,
  input  wire logic [7:0] pull_up_en,
  input  wire logic [7:0] pull_down_en,
  input  wire logic [7:0] press_en,
  input  wire logic [7:0] press_lvl,
  output wire logic [7:0] kbd_pin
);
  logic [7:0] float_pat = 8'h55;
  // an undriven, unpulled line keeps changing so it never looks settled
  always @(posedge core_clk) begin
    float_pat <= ~float_pat;
  end
  // a released line follows the pull that the block selects
  assign kbd_pin = (press_en & press_lvl) | (~press_en & pull_up_en)
    | (~press_en & ~pull_up_en & ~pull_down_en & float_pat);
endmodule

// File: kpi_tb.sv
// testbench of the keypad pin interrupt block
`timescale 1ns/1ps
module testbench;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] press_en = 8'h00;
  logic [7:0] press_lvl = 8'h00;
  wire  [7:0] reg_rdata;
  wire  [7:0] kbd_pin;
  wire        irq;
  wire  [7:0] pull_up_en;
  wire  [7:0] pull_down_en;
  int         err_count = 0;
  int         num_checks = 0;
  logic [7:0] d;
  always #20 core_clk = ~core_clk;
  kpi_top dut_u (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .kbd_pin(kbd_pin), .irq(irq),
    .pull_up_en(pull_up_en), .pull_down_en(pull_down_en));
  kpi_keys keys_u (.core_clk(core_clk), .pull_up_en(pull_up_en), .pull_down_en(pull_down_en),
    .press_en(press_en), .press_lvl(press_lvl), .kbd_pin(kbd_pin));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks = num_checks + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] v;
    rd(a, v);
    chk(v, exp);
  endtask
  task automatic keys(input logic [7:0] en, input logic [7:0] lvl, input int n);
    @(posedge core_clk);
    press_en <= en;
    press_lvl <= lvl;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // mask, polarity, pulls, enables, acknowledge, unmask
  task automatic cfg(input logic [7:0] pol, input logic [7:0] pull, input logic [7:0] pe,
                     input logic mode);
    wr(4'h0, {7'h00, mode});
    wr(4'h1, 8'h00);
    wr(4'h2, pol);
    wr(4'h3, pull);
    wr(4'h1, pe);
    wr(4'h0, {7'h00, mode} | 8'h04);
    wr(4'h0, {7'h00, mode} | 8'h02);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    for (int a = 0; a < 16; a++) rdchk(a[3:0], 8'h00);
    chk({7'h00, irq}, 8'h00);
    $display("t_reset done");
  endtask
  task automatic t_fall;
    cfg(8'h00, 8'h01, 8'h01, 1'b0);
    chk(pull_up_en, 8'h01);
    chk(pull_down_en, 8'h00);
    keys(8'h01, 8'h00, 4);
    chk({7'h00, irq}, 8'h01);
    rdchk(4'h0, 8'h0a);
    wr(4'h0, 8'h0a);
    rdchk(4'h0, 8'h0a);
    keys(8'h00, 8'h00, 2);
    wr(4'h0, 8'h06);
    rdchk(4'h0, 8'h02);
    chk({7'h00, irq}, 8'h00);
    wr(4'h0, 8'h0a);
    rdchk(4'h0, 8'h02);
    $display("t_fall done");
  endtask
  task automatic t_rise;
    cfg(8'h06, 8'h06, 8'h06, 1'b0);
    chk(pull_down_en, 8'h06);
    chk(pull_up_en, 8'h00);
    keys(8'h00, 8'h00, 6);
    rdchk(4'h0, 8'h02);
    keys(8'h02, 8'h02, 4);
    rdchk(4'h0, 8'h0a);
    wr(4'h0, 8'h06);
    keys(8'h06, 8'h06, 4);
    rdchk(4'h0, 8'h02);
    keys(8'h00, 8'h00, 3);
    keys(8'h04, 8'h04, 4);
    rdchk(4'h0, 8'h0a);
    keys(8'h00, 8'h00, 2);
    $display("t_rise done");
  endtask
  task automatic t_level;
    cfg(8'h00, 8'h01, 8'h01, 1'b1);
    keys(8'h01, 8'h00, 4);
    rdchk(4'h0, 8'h0b);
    wr(4'h0, 8'h07);
    rdchk(4'h0, 8'h0b);
    rd(4'h4, d);
    chk(d & 8'h04, 8'h04);
    keys(8'h00, 8'h00, 3);
    wr(4'h0, 8'h07);
    rdchk(4'h0, 8'h03);
    chk({7'h00, irq}, 8'h00);
    $display("t_level done");
  endtask
  task automatic t_events;
    wr(4'h5, 8'h07);
    rdchk(4'h4, 8'h00);
    wr(4'h6, 8'h04);
    rdchk(4'h6, 8'h04);
    wr(4'h0, 8'h01);
    keys(8'h01, 8'h00, 4);
    wr(4'h0, 8'h05);
    keys(8'h01, 8'h00, 2);
    chk({7'h00, irq}, 8'h01);
    wr(4'h6, 8'h00);
    keys(8'h01, 8'h00, 2);
    chk({7'h00, irq}, 8'h00);
    wr(4'h5, 8'h04);
    rd(4'h4, d);
    chk(d & 8'h04, 8'h00);
    keys(8'h00, 8'h00, 2);
    $display("t_events done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset;
    t_fall;
    t_rise;
    t_level;
    t_events;
    test_done;
  end
  initial begin
    #400000;
    err_count = err_count + 1;
    test_done;
  end
endmodule
